// ---- hdl/stra_regs.svh ----
// Register map, field positions, reset values and fixed codes of the range check.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
`ifndef STRA_REGS_SVH
`define STRA_REGS_SVH
`define STRA_OFS_CTRL     8'h00
`define STRA_OFS_HOFS     8'h04
`define STRA_OFS_STAT     8'h08
`define STRA_OFS_MASK     8'h0c
`define STRA_OFS_POS      8'h10
`define STRA_OFS_STATE    8'h14
`define STRA_OFS_ALM      8'h18
`define STRA_CTRL_MODE_LO 0
`define STRA_CTRL_SEQ_LO  4
`define STRA_CTRL_ACLR    8
`define STRA_STAT_RNG     0
`define STRA_STAT_CMD     1
`define STRA_CTRL_RST     3'h0
`define STRA_SEQ_RST      3'h0
`define STRA_HOFS_RST     32'h0000_0000
`define STRA_MASK_RST     2'h0
`define STRA_MODE_MAX     3'h4
`define STRA_ERR_MAIN     8'h22
`define STRA_ERR_SUB      4'h1
`endif

// ---- hdl/stra_pkg.sv ----
// Types shared by the single-turn range check and its test bench.
// Assumes the constants header is included by the design files.
package stra_pkg;
	typedef enum logic [2:0] {
		STRA_ABS      = 3'b000,
		STRA_INC      = 3'b001,
		STRA_ABS_NOOV = 3'b010,
		STRA_SINGLE   = 3'b011,
		STRA_ABS_LIM  = 3'b100
	} stra_mode_t;

	typedef struct packed {
		logic sys_down;
		logic cnt_ovf;
		logic ovr_spd;
		logic mt_cnt;
		logic battery;
	} stra_alm_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] pos;
	} stra_cmd_t;
endpackage

// ---- hdl/stra_turn_track.sv ----
// Tracks the unwrapped encoder position from single-turn samples.
// Assumes samples arrive often enough that one step is under half a turn.
`timescale 1ns/100ps
module stra_turn_track #(
	parameter int ENC_W = 23
) (
	// Clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// Encoder samples
	input  wire logic               smp_vld,
	input  wire logic [ENC_W-1:0]   smp_pos,
	// Tracked position
	output logic signed [ENC_W+1:0] coord_ff,
	output logic                    capt_ff,
	output logic                    out_rng
);
	localparam logic signed [ENC_W+1:0] TOP = (ENC_W+2)'((1 << ENC_W) - 1);

	logic [ENC_W-1:0]        last_ff;
	logic signed [ENC_W-1:0] step;
	logic signed [ENC_W+1:0] nxt_coord;

	// Modular difference, so a wrap of the single-turn value is a small step.
	function automatic logic signed [ENC_W-1:0] wrap_diff(input logic [ENC_W-1:0] a,
		input logic [ENC_W-1:0] b);
		wrap_diff = $signed(a - b);
	endfunction

	assign step      = wrap_diff(smp_pos, last_ff);
	// The first sample after power-up fixes the range origin.
	assign nxt_coord = capt_ff ? coord_ff + (ENC_W+2)'(step) : (ENC_W+2)'({2'b00, smp_pos});
	// Range is one turn of single-turn data in tracked coordinates.
	assign out_rng   = capt_ff && (coord_ff < 0 || coord_ff > TOP);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			coord_ff <= '0;
			last_ff  <= '0;
			capt_ff  <= 1'b0;
		end else if (smp_vld) begin
			coord_ff <= nxt_coord;
			last_ff  <= smp_pos;
			capt_ff  <= 1'b1;
		end
	end
endmodule

// ---- hdl/stra_range_chk.sv ----
// Single-turn absolute range check with AHB-Lite registers and command gate.
// Assumes encoder samples, alarms and host commands are synchronous to hclk.
//
// What this block does
// - Encoder use method picks one of five modes, codes 0 to 4.
// - Range checking is active only when the use method is 3.
// - Works in every control mode but needs an absolute encoder present.
// - Leaving the one-turn working range raises range error 34.1.
// - Range error stops the motor with the configured alarm stop sequence.
// - Host commands outside the working range are refused with an error answer.
// - Multi-turn data and all five absolute encoder alarms are ignored when the use method is 3.
// - Home offset separates raw encoder position from mechanical coordinates.
// - Working range is one turn fixed from the position at power-up.
// - Powering up near a range edge lets slight motion raise the error.
`include "stra_regs.svh"
`timescale 1ns/100ps
module stra_range_chk #(
	parameter int ENC_W = 23,
	parameter int MT_W  = 16
) (
	// Clock and reset
	input  wire logic                hclk,
	input  wire logic                hresetn,
	// AHB-Lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	// Encoder
	input  wire logic                enc_present,
	input  wire logic                enc_vld,
	input  wire logic [ENC_W-1:0]    enc_pos,
	input  wire logic [MT_W-1:0]     enc_mt,
	input  wire stra_pkg::stra_alm_t abs_alm_in,
	// Host commands
	input  wire stra_pkg::stra_cmd_t cmd_in,
	output logic                     cmd_rdy,
	output logic                     cmd_ack_ff,
	output logic                     cmd_nak_ff,
	output logic [31:0]              tgt_pos_ff,
	// Alarm and stop
	input  wire logic                alarm_clear,
	output stra_pkg::stra_alm_t      abs_alm_ff,
	output logic                     stop_req_ff,
	output logic [2:0]               stop_seq_ff,
	output logic [7:0]               err_main_ff,
	output logic [3:0]               err_sub_ff,
	output logic [31:0]              mech_pos_ff,
	output stra_pkg::stra_mode_t     mode_ff,
	output logic                     irq
);
	import stra_pkg::*;

	localparam logic signed [33:0] TOP = 34'((1 << ENC_W) - 1);

	// Word positions are compared with two guard bits so no sum can wrap.
	function automatic logic signed [33:0] sext34(input logic [31:0] v);
		sext34 = $signed({{2{v[31]}}, v});
	endfunction

	// A position beyond either edge of the one-turn range.
	function automatic logic beyond(input logic signed [33:0] v);
		beyond = v < 0 || v > TOP;
	endfunction

	// Bus pipeline state
	logic        wr_ph_ff;
	logic        rd_ph_ff;
	logic [7:0]  addr_ff;
	logic        take;
	logic        take_wr;
	logic        take_rd;

	// Registers
	logic [2:0]  seq_ff;
	logic [31:0] hofs_ff;
	logic [1:0]  stat_ff;
	logic [1:0]  mask_ff;
	logic [31:0] hrdata_ff;

	// Decodes
	logic        wr_ctrl;
	logic        wr_hofs;
	logic        wr_stat;
	logic        wr_mask;
	logic [2:0]  wr_mode;
	logic        mode_ok;
	logic [31:0] rd_mux;
	logic        sel_ctrl;
	logic        sel_hofs;
	logic        sel_stat;
	logic        sel_mask;
	logic        sel_pos;
	logic        sel_state;
	logic        sel_alm;

	// Tracking and range
	logic signed [ENC_W+1:0] coord;
	logic                    capt;
	logic                    out_rng;
	logic                    active;
	logic                    rng_err_ff;
	logic                    nxt_rng_err;
	logic                    aclr;
	logic                    rng_set;

	// Command path
	logic signed [33:0] cmd_enc;
	logic               cmd_bad;
	logic               cmd_take;

	// Positions
	logic signed [33:0] mech_s;
	logic [31:0]        mech_multi;

	// Interrupt status
	logic [1:0]  ev;
	logic [1:0]  nxt_stat;
	logic [3:0]  state_word;

	// A transfer is taken only on an active cycle of a selected slave.
	assign take    = hsel && hready && htrans[1];
	assign take_wr = take && hwrite;
	assign take_rd = take && !hwrite;

	// Reads take one wait state so that a write just before them is seen.
	assign hreadyout = !rd_ph_ff;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;

	// One offset compare per register serves both the write and the read path.
	assign sel_ctrl  = addr_ff == `STRA_OFS_CTRL;
	assign sel_hofs  = addr_ff == `STRA_OFS_HOFS;
	assign sel_stat  = addr_ff == `STRA_OFS_STAT;
	assign sel_mask  = addr_ff == `STRA_OFS_MASK;
	assign sel_pos   = addr_ff == `STRA_OFS_POS;
	assign sel_state = addr_ff == `STRA_OFS_STATE;
	assign sel_alm   = addr_ff == `STRA_OFS_ALM;

	assign wr_ctrl = wr_ph_ff && sel_ctrl;
	assign wr_hofs = wr_ph_ff && sel_hofs;
	assign wr_stat = wr_ph_ff && sel_stat;
	assign wr_mask = wr_ph_ff && sel_mask;

	// Codes above the last mode are refused and the old mode stays.
	assign wr_mode = hwdata[`STRA_CTRL_MODE_LO +: 3];
	assign mode_ok = wr_mode <= `STRA_MODE_MAX;

	// Self-clearing alarm clear, from software or from the operator pin.
	assign aclr = alarm_clear || (wr_ctrl && hwdata[`STRA_CTRL_ACLR]);

	assign state_word = {out_rng, rng_err_ff, capt, active};

	// Unmapped offsets select nothing and read as zero.
	assign rd_mux = ({32{sel_ctrl}} & {21'h0, 3'h0, 1'b0, seq_ff, 1'b0, mode_ff})
		| ({32{sel_hofs}} & hofs_ff)
		| ({32{sel_stat}} & {30'h0, stat_ff})
		| ({32{sel_mask}} & {30'h0, mask_ff})
		| ({32{sel_pos}} & mech_pos_ff)
		| ({32{sel_state}} & {28'h0, state_word})
		| ({32{sel_alm}} & {16'h0, err_main_ff, err_sub_ff, 4'h0});

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_ff <= 1'b0;
			rd_ph_ff <= 1'b0;
		end else begin
			wr_ph_ff <= take_wr;
			rd_ph_ff <= take_rd;
		end
	end

	// The address is kept through wait states, so the read mux stays put.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_ff <= 8'h00;
		end else if (take) begin
			addr_ff <= {haddr[7:2], 2'b00};
		end
	end

	// Read data are registered so hrdata holds still until the next read.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (rd_ph_ff) begin
			hrdata_ff <= rd_mux;
		end
	end

	// A refused mode code still lets the stop sequence field be written.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_ff <= stra_mode_t'(`STRA_CTRL_RST);
			seq_ff  <= `STRA_SEQ_RST;
		end else if (wr_ctrl) begin
			if (mode_ok) begin
				mode_ff <= stra_mode_t'(wr_mode);
			end
			seq_ff <= hwdata[`STRA_CTRL_SEQ_LO +: 3];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hofs_ff <= `STRA_HOFS_RST;
			mask_ff <= `STRA_MASK_RST;
		end else begin
			if (wr_hofs) begin
				hofs_ff <= hwdata;
			end
			if (wr_mask) begin
				mask_ff <= hwdata[1:0];
			end
		end
	end

	// Only method 3 with an absolute encoder fitted enables the check.
	// Control mode plays no part, so position, velocity and torque all apply.
	assign active = mode_ff == STRA_SINGLE && enc_present;

	// The tracker restarts on every reset, which stands for a power-up.
	stra_turn_track #(
		.ENC_W (ENC_W)
	) u_track (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.smp_vld  (enc_vld),
		.smp_pos  (enc_pos),
		.coord_ff (coord),
		.capt_ff  (capt),
		.out_rng  (out_rng)
	);

	// Any step past either edge counts, however small.
	assign rng_set     = active && out_rng;
	// A new excursion in the clearing cycle wins over the clear.
	assign nxt_rng_err = rng_set || (rng_err_ff && !aclr);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rng_err_ff <= 1'b0;
		end else begin
			rng_err_ff <= nxt_rng_err;
		end
	end

	// The stop stays requested for as long as the error is latched.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_req_ff <= 1'b0;
			stop_seq_ff <= `STRA_SEQ_RST;
		end else begin
			stop_req_ff <= nxt_rng_err;
			stop_seq_ff <= seq_ff;
		end
	end

	// The error code follows the latch, so it reads zero once cleared.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_main_ff <= 8'h00;
			err_sub_ff  <= 4'h0;
		end else begin
			err_main_ff <= nxt_rng_err ? `STRA_ERR_MAIN : 8'h00;
			err_sub_ff  <= nxt_rng_err ? `STRA_ERR_SUB : 4'h0;
		end
	end

	// Mechanical coordinate plus offset gives the encoder coordinate.
	assign cmd_enc  = sext34(cmd_in.pos) + sext34(hofs_ff);
	// The host is trusted to stay in range; this gate catches it if not.
	assign cmd_bad  = active && beyond(cmd_enc);
	// Each command is judged in the cycle it arrives, so it is never held off.
	assign cmd_rdy  = 1'b1;
	assign cmd_take = cmd_in.valid && cmd_rdy;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_ack_ff <= 1'b0;
			cmd_nak_ff <= 1'b0;
			tgt_pos_ff <= 32'h0000_0000;
		end else begin
			cmd_ack_ff <= cmd_take && !cmd_bad;
			cmd_nak_ff <= cmd_take && cmd_bad;
			if (cmd_take && !cmd_bad) begin
				tgt_pos_ff <= cmd_in.pos;
			end
		end
	end

	// Single-turn mode drops the turn count from the reported position.
	assign mech_s     = 34'(coord) - sext34(hofs_ff);
	// Elsewhere the turn count sits above the single-turn value; the word wraps.
	assign mech_multi = 32'({enc_mt, enc_pos}) - hofs_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mech_pos_ff <= 32'h0000_0000;
		end else if (mode_ff == STRA_SINGLE) begin
			mech_pos_ff <= mech_s[31:0];
		end else begin
			mech_pos_ff <= mech_multi;
		end
	end

	// All five absolute encoder alarms, battery and multi-turn among them, are masked off in single-turn mode.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			abs_alm_ff <= '0;
		end else if (mode_ff == STRA_SINGLE) begin
			abs_alm_ff <= '0;
		end else begin
			abs_alm_ff <= abs_alm_in;
		end
	end

	// Sticky events; a set in the same cycle as its clear wins.
	assign ev       = {cmd_take && cmd_bad, rng_set && !rng_err_ff};
	assign nxt_stat = ev | (stat_ff & ~(wr_stat ? hwdata[1:0] : 2'h0));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_ff <= 2'h0;
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	assign irq = |(stat_ff & mask_ff);

	// Transfer size is not checked: only whole-word access is supported.
	// Upper address bits are not decoded, so the map repeats every 256 bytes.
	logic unused_ok;
	assign unused_ok = &{1'b0, hsize, haddr[31:8], haddr[1:0]};
endmodule

// ---- test/stra_range_chk_monitor.sv ----
// Checker of the single-turn range check, seeing only its top ports.
// Assumes one clock hclk and the active-low reset hresetn.
`timescale 1ns/100ps
module stra_range_mon (
	// Bus
	input wire logic                hclk,
	input wire logic                hresetn,
	input wire logic                hsel,
	input wire logic [1:0]          htrans,
	input wire logic                hwrite,
	input wire logic                hready,
	input wire logic                hreadyout,
	input wire logic                hresp,
	// Commands
	input wire logic                enc_present,
	input wire stra_pkg::stra_cmd_t cmd_in,
	input wire logic                cmd_ack_ff,
	input wire logic                cmd_nak_ff,
	input wire logic [31:0]         tgt_pos_ff,
	// Alarm
	input wire logic                alarm_clear,
	input wire stra_pkg::stra_alm_t abs_alm_ff,
	input wire logic                stop_req_ff,
	input wire logic [7:0]          err_main_ff,
	input wire logic [3:0]          err_sub_ff,
	input wire stra_pkg::stra_mode_t mode_ff
);
	import stra_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	okay_resp_a: assert property (hresp == 1'b0)
		else $error("Response not okay.");
	read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("Read wait state wrong.");
	cmd_answer_a: assert property (cmd_in.valid |=> cmd_ack_ff != cmd_nak_ff)
		else $error("Command not answered once.");
	ack_target_a: assert property (cmd_ack_ff |-> tgt_pos_ff == $past(cmd_in.pos))
		else $error("Target not the accepted position.");
	nak_scope_a: assert property (cmd_nak_ff |-> $past(enc_present) && $past(mode_ff) == STRA_SINGLE)
		else $error("Refusal outside range mode.");
	err_code_a: assert property (err_main_ff == (stop_req_ff ? 8'h22 : 8'h00) && err_sub_ff == {3'h0, stop_req_ff})
		else $error("Error code wrong.");
	stop_cause_a: assert property ($rose(stop_req_ff) |-> $past(enc_present) && $past(mode_ff) == STRA_SINGLE)
		else $error("Stop outside range mode.");
	err_latch_a: assert property (stop_req_ff && !alarm_clear && !$past(hsel) |=> stop_req_ff)
		else $error("Range error dropped without clear.");
	alm_mask_a: assert property (mode_ff == STRA_SINGLE && $past(mode_ff) == STRA_SINGLE |-> abs_alm_ff == '0)
		else $error("Multi-turn alarm seen in range mode.");
endmodule
bind stra_range_chk stra_range_mon stra_range_mon_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.enc_present(enc_present), .cmd_in(cmd_in), .cmd_ack_ff(cmd_ack_ff), .cmd_nak_ff(cmd_nak_ff),
	.tgt_pos_ff(tgt_pos_ff), .alarm_clear(alarm_clear), .abs_alm_ff(abs_alm_ff),
	.stop_req_ff(stop_req_ff), .err_main_ff(err_main_ff), .err_sub_ff(err_sub_ff), .mode_ff(mode_ff));

// ---- test/stra_host_model.sv ----
// Host motion controller that issues position commands.
// Assumes a command is taken at a rising hclk edge.
`timescale 1ns/100ps
module stra_host_model (
	// Clock
	input wire logic            hclk,
	// Command
	output stra_pkg::stra_cmd_t cmd
);
	import stra_pkg::*;
	initial cmd = '0;
	// The position is inverted once released, so a stale value is never mistaken for a request.
	task automatic send(input logic [31:0] p);
		@(posedge hclk);
		cmd <= '{valid: 1'b1, pos: p};
		@(posedge hclk);
		cmd <= '{valid: 1'b0, pos: ~p};
	endtask
endmodule

// ---- test/testbench.sv ----
// Self-checking bench of the single-turn range check.
// Assumes the host model drives commands and the bench is the bus master.
`timescale 1ns/100ps
module testbench;
	import stra_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, tgt_pos_ff, mech_pos_ff, rd;
	logic        hreadyout, hresp, cmd_rdy, cmd_ack_ff, cmd_nak_ff, stop_req_ff, irq;
	logic        enc_present = 1'b1, enc_vld = 1'b0, alarm_clear = 1'b0;
	logic [22:0] enc_pos = '0;
	logic [15:0] enc_mt = 16'h0000;
	logic [2:0]  stop_seq_ff;
	logic [7:0]  err_main_ff;
	logic [3:0]  err_sub_ff;
	stra_alm_t   abs_alm_in = '0, abs_alm_ff;
	stra_cmd_t   cmd_in;
	stra_mode_t  mode_ff;
	int          fails = 0, checks_done = 0;
	always #25 hclk = ~hclk;
	stra_host_model stra_host_model_i (.hclk(hclk), .cmd(cmd_in));
	stra_range_chk stra_range_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .enc_present(enc_present),
		.enc_vld(enc_vld), .enc_pos(enc_pos), .enc_mt(enc_mt), .abs_alm_in(abs_alm_in),
		.cmd_in(cmd_in), .cmd_rdy(cmd_rdy), .cmd_ack_ff(cmd_ack_ff), .cmd_nak_ff(cmd_nak_ff),
		.tgt_pos_ff(tgt_pos_ff), .alarm_clear(alarm_clear), .abs_alm_ff(abs_alm_ff),
		.stop_req_ff(stop_req_ff), .stop_seq_ff(stop_seq_ff), .err_main_ff(err_main_ff),
		.err_sub_ff(err_sub_ff), .mech_pos_ff(mech_pos_ff), .mode_ff(mode_ff), .irq(irq));
	task automatic tally_and_finish;
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			tally_and_finish;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		ready;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		ready;
		rd = hrdata;
	endtask
	task automatic enc(input logic [22:0] p);
		@(posedge hclk);
		enc_vld <= 1'b1;
		enc_pos <= p;
		@(posedge hclk);
		enc_vld <= 1'b0;
		repeat (2) @(posedge hclk);
		#1;
	endtask
	task automatic cmd(input logic [31:0] p, input logic nak);
		stra_host_model_i.send(p);
		#1;
		chk({cmd_ack_ff, cmd_nak_ff}, {~nak, nak});
		if (!nak)
			chk(tgt_pos_ff, p);
	endtask
	task automatic t_reset;
		chk({mode_ff, stop_req_ff, irq, hreadyout, cmd_rdy}, 7'h03);
		for (int a = 0; a < 36; a += 4) begin
			bus(1'b0, a[7:0], '0);
			chk(rd, '0);
		end
	endtask
	task automatic t_modes;
		for (int m = 0; m < 5; m++) begin
			bus(1'b1, 8'h00, m | (m << 4));
			@(posedge hclk);
			#1;
			chk({stop_seq_ff, mode_ff}, {m[2:0], m[2:0]});
		end
		bus(1'b1, 8'h00, 32'h77);
		@(posedge hclk);
		#1;
		chk({stop_seq_ff, mode_ff}, 6'h3c);
	endtask
	task automatic t_alarms;
		abs_alm_in <= 5'h1f;
		enc_mt <= 16'h0001;
		bus(1'b1, 8'h00, 32'h0);
		repeat (2) @(posedge hclk);
		#1;
		chk(abs_alm_ff, 5'h1f);
		chk(mech_pos_ff, 32'h0080_0000);
		bus(1'b1, 8'h00, 32'h3);
		repeat (2) @(posedge hclk);
		#1;
		chk(abs_alm_ff, 5'h00);
		chk(mech_pos_ff, 32'h0000_0000);
		abs_alm_in <= 5'h0;
		enc_mt <= 16'h0000;
	endtask
	task automatic t_cmds;
		int p [8] = '{0, -1, 8388607, 8388608, -10000, -10001, 8378607, 8378608};
		for (int i = 0; i < 8; i++) begin
			if (i == 4)
				bus(1'b1, 8'h04, 32'd10000);
			cmd(p[i], i[0]);
		end
		bus(1'b0, 8'h08, '0);
		chk(rd[1], 1'b1);
		bus(1'b1, 8'h08, 32'h3);
		enc_present <= 1'b0;
		cmd(-32'sd20000, 1'b0);
		enc_present <= 1'b1;
		bus(1'b1, 8'h00, 32'h1);
		cmd(-32'sd20000, 1'b0);
		bus(1'b1, 8'h00, 32'h3);
	endtask
	task automatic t_range;
		bus(1'b1, 8'h0c, 32'h1);
		enc(23'd8388600);
		chk(stop_req_ff, 1'b0);
		chk(mech_pos_ff, 32'd8378600);
		enc(23'd8388607);
		chk(stop_req_ff, 1'b0);
		enc(23'd2);
		chk({stop_req_ff, irq, err_main_ff, err_sub_ff}, 14'h3221);
		bus(1'b0, 8'h18, '0);
		chk(rd, 32'h0000_2210);
		bus(1'b0, 8'h14, '0);
		chk(rd, 32'h0000_000f);
		enc(23'd8388600);
		chk(stop_req_ff, 1'b1);
		bus(1'b1, 8'h0c, 32'h0);
		#1;
		chk(irq, 1'b0);
		bus(1'b1, 8'h0c, 32'h1);
		bus(1'b0, 8'h08, '0);
		chk(irq, 1'b1);
		chk(rd, 32'h1);
		bus(1'b1, 8'h08, 32'h1);
		#1;
		chk(irq, 1'b0);
		alarm_clear <= 1'b1;
		@(posedge hclk);
		alarm_clear <= 1'b0;
		@(posedge hclk);
		#1;
		chk({stop_req_ff, err_main_ff}, 9'h0);
	endtask
	task automatic t_power;
		enc(23'd2);
		chk(stop_req_ff, 1'b1);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b1, 8'h00, 32'h3);
		enc(23'd2);
		chk(stop_req_ff, 1'b0);
		enc(23'd8388600);
		chk(stop_req_ff, 1'b1);
	endtask
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_modes;
		t_alarms;
		t_cmds;
		t_range;
		t_power;
		tally_and_finish;
	end
endmodule
